// *** design/ridc_defs.vh ***
/*
 * Constants for the identity store and its serial CRC-8 check.
 * Assumes it is included by bare name from every design file that needs it.
 */
// Behaviour
// - The identity word is 64 bits, with an 8-bit family code at the bottom and a 48-bit serial number above it.
// - The top 8 bits of the identity word are a check byte computed over the 56 family and serial bits.
// - The check byte comes from an 8-bit shift register whose XOR taps give the polynomial x^8 + x^5 + x^4 + 1.
// - Every stage of the check register is cleared to zero before the first bit is accumulated.
// - Bits enter the check register one per step, family code first from its lowest bit, then the serial number.
// - Shifting the 8 check bits in after the 56 data bits leaves the register at zero, which marks a pass.
// - Only after one of five identity-level commands has completed is one of four memory commands accepted.
// - Every byte on the link, in either direction, moves least significant bit first.
`ifndef RIDC_DEFS_VH
`define RIDC_DEFS_VH

// ----------------------------------------------------------------------
// Identity word layout
// ----------------------------------------------------------------------
`define RIDC_ID_W 64
`define RIDC_FAMILY_LSB 0
`define RIDC_FAMILY_W 8
`define RIDC_SERIAL_LSB 8
`define RIDC_SERIAL_W 48
`define RIDC_CHECK_LSB 56
`define RIDC_CHECK_W 8
`define RIDC_DATA_BITS 56

// ----------------------------------------------------------------------
// Check register
// ----------------------------------------------------------------------
`define RIDC_CRC_INIT 8'h00
`define RIDC_CRC_POLY_REV 8'h8C
`define RIDC_INIT_LATCH 7'h38
`define RIDC_INIT_LAST 7'h40
`define RIDC_INIT_DONE 7'h41

// ----------------------------------------------------------------------
// Link framing
// ----------------------------------------------------------------------
`define RIDC_BYTE_W 8
`define RIDC_LAST_ID_BIT 6'h3F
`define RIDC_LAST_BYTE_BIT 3'h7

`endif

// *** design/ridc_crc8.v ***
/*
 * Serial CRC-8 generator, one bit per enabled clock, lowest bit first.
 * Assumes the caller clears it before a new word and holds en_i low otherwise.
 */
`timescale 1ns/1ps
`include "ridc_defs.vh"

module ridc_crc8 (
    input wire mclk_i,
    input wire resetn_i,
    input wire clr_i,
    input wire en_i,
    input wire bit_i,
    output wire [7:0] crc_o
);
    reg [7:0] crc_reg;
    wire fb;

    // -----------------------------------------------------------------
    // Feedback tap
    // -----------------------------------------------------------------
    // The reflected form lets the incoming bit meet stage 0 directly.
    assign fb = crc_reg[0] ^ bit_i;

    // Shift right and fold the feedback into the x^5 and x^4 stages.
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crc_reg <= `RIDC_CRC_INIT;
        end else if (clr_i) begin
            crc_reg <= `RIDC_CRC_INIT;
        end else if (en_i) begin
            crc_reg <= {fb, crc_reg[7:1]} ^ (fb ? (`RIDC_CRC_POLY_REV & 8'h7F) : 8'h00);
        end
    end

    assign crc_o = crc_reg;
endmodule

// *** design/ridc_fifo2.v ***
/*
 * Small FIFO with valid and ready on both sides, default two entries.
 * Assumes DEPTH is a power of two and the drain side may stall at will.
 */
`timescale 1ns/1ps

module ridc_fifo2 #(
    parameter WIDTH = 1,
    parameter DEPTH = 2,
    parameter AW = 1
) (
    input wire mclk_i,
    input wire resetn_i,
    input wire flush_i,
    input wire in_valid_i,
    input wire [WIDTH-1:0] in_data_i,
    output wire in_ready_o,
    output wire out_valid_o,
    output wire [WIDTH-1:0] out_data_o,
    input wire out_ready_i
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;
    integer i;

    // -----------------------------------------------------------------
    // Handshakes
    // -----------------------------------------------------------------
    // Full and empty come from the occupancy count, so neither side lies.
    assign in_ready_o = (count_reg != DEPTH[AW:0]);
    assign out_valid_o = (count_reg != {(AW+1){1'b0}});
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_reg[rd_ptr_reg];

    // Storage and pointers; a flush drops whatever a dead frame left.
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_reg[i] <= {WIDTH{1'b0}};
            end
        end else if (flush_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data_i;
                wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// *** design/ridc_top.v ***
/*
 * Identity store of a single-wire slave: 64-bit identity with its CRC-8
 * check byte, the identity-level command layer, and the gate that admits
 * memory commands only after a successful identity command.
 * Assumes link bits arrive already sliced, one rx_valid_i pulse per bit,
 * and that link_reset_i pulses once for each reset and presence cycle.
 */
`timescale 1ns/1ps
`include "ridc_defs.vh"

module ridc_top #(
    parameter [7:0] FAMILY_CODE = 8'h5A,              // Arbitrary value.
    parameter [47:0] SERIAL_NUMBER = 48'h0123456789AB, // Arbitrary value.
    parameter [7:0] CMD_READ_ID = 8'hA1,
    parameter [7:0] CMD_MATCH_ID = 8'hA2,
    parameter [7:0] CMD_SEARCH_ID = 8'hA3,
    parameter [7:0] CMD_SKIP_ID = 8'hA4,
    parameter [7:0] CMD_RESUME = 8'hA5,
    parameter [7:0] CMD_MEM_0 = 8'hB1,
    parameter [7:0] CMD_MEM_1 = 8'hB2,
    parameter [7:0] CMD_MEM_2 = 8'hB3,
    parameter [7:0] CMD_MEM_3 = 8'hB4
) (
    input wire mclk_i,
    input wire resetn_i,
    input wire link_reset_i,
    input wire rx_valid_i,
    input wire rx_bit_i,
    input wire tx_ready_i,
    output wire tx_valid_o,
    output wire tx_bit_o,
    output wire id_ready_o,
    output wire id_crc_ok_o,
    output wire [7:0] id_crc_o,
    output wire selected_o,
    output wire mem_cmd_valid_o,
    output wire [7:0] mem_cmd_o,
    output wire mem_data_valid_o,
    output wire [7:0] mem_data_o,
    output wire cmd_reject_o
);
    // -----------------------------------------------------------------
    // States
    // -----------------------------------------------------------------
    localparam [7:0] S_INIT = 8'h01;
    localparam [7:0] S_IDLE = 8'h02;
    localparam [7:0] S_ROMCMD = 8'h04;
    localparam [7:0] S_READ = 8'h08;
    localparam [7:0] S_MATCH = 8'h10;
    localparam [7:0] S_SEARCH = 8'h20;
    localparam [7:0] S_MEMCMD = 8'h40;
    localparam [7:0] S_DATA = 8'h80;

    localparam [1:0] PH_TRUE = 2'h0;
    localparam [1:0] PH_COMP = 2'h1;
    localparam [1:0] PH_PICK = 2'h2;

    reg [7:0] state_reg;
    reg [6:0] init_cnt_reg;
    reg [7:0] id_crc_reg;
    reg id_ready_reg;
    reg id_crc_ok_reg;
    reg [5:0] idx_reg;
    reg [1:0] phase_reg;
    reg mismatch_reg;
    reg [7:0] rx_shift_reg;
    reg [2:0] rx_cnt_reg;
    reg selected_reg;
    reg resume_reg;
    reg mem_cmd_valid_reg;
    reg [7:0] mem_cmd_reg;
    reg mem_data_valid_reg;
    reg [7:0] mem_data_reg;
    reg cmd_reject_reg;

    wire [63:0] id_word;
    wire [7:0] crc_out;
    wire [2:0] crc_sel;
    wire crc_clr;
    wire crc_en;
    wire crc_bit;
    wire id_bit;
    wire [7:0] rx_byte;
    wire byte_done;
    wire push_valid;
    wire push_bit;
    wire push_ready;
    wire push_fire;
    wire is_mem_cmd;
    wire is_rom_cmd;

    // -----------------------------------------------------------------
    // Identity word
    // -----------------------------------------------------------------
    // Family code in the low byte, serial above it, check byte on top.
    assign id_word[`RIDC_FAMILY_LSB +: `RIDC_FAMILY_W] = FAMILY_CODE;
    assign id_word[`RIDC_SERIAL_LSB +: `RIDC_SERIAL_W] = SERIAL_NUMBER;
    assign id_word[`RIDC_CHECK_LSB +: `RIDC_CHECK_W] = id_crc_reg;
    assign id_bit = id_word[idx_reg];

    // -----------------------------------------------------------------
    // Check byte generation after reset
    // -----------------------------------------------------------------
    // Steps 0..55 feed data bits, step 56 only latches the result, and
    // steps 57..64 feed the latched byte back so the register must empty.
    assign crc_sel = init_cnt_reg[2:0] - 3'h1;
    assign crc_clr = (state_reg != S_INIT); // Parked at zero once the self-check is over.
    assign crc_en = (state_reg == S_INIT) && (init_cnt_reg != `RIDC_INIT_LATCH) &&
                    (init_cnt_reg <= `RIDC_INIT_LAST);
    assign crc_bit = (init_cnt_reg < `RIDC_INIT_LATCH) ?
                     id_word[init_cnt_reg[5:0]] : id_crc_reg[crc_sel];

    ridc_crc8 u_crc (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .clr_i(crc_clr),
        .en_i(crc_en),
        .bit_i(crc_bit),
        .crc_o(crc_out)
    );

    // -----------------------------------------------------------------
    // Receive byte assembly
    // -----------------------------------------------------------------
    // The first bit on the wire lands in bit 0 of the byte.
    assign rx_byte = {rx_bit_i, rx_shift_reg[7:1]};
    assign byte_done = rx_valid_i && (rx_cnt_reg == `RIDC_LAST_BYTE_BIT);

    assign is_rom_cmd = (rx_byte == CMD_READ_ID) || (rx_byte == CMD_MATCH_ID) ||
                        (rx_byte == CMD_SEARCH_ID) || (rx_byte == CMD_SKIP_ID) ||
                        (rx_byte == CMD_RESUME);
    assign is_mem_cmd = (rx_byte == CMD_MEM_0) || (rx_byte == CMD_MEM_1) ||
                        (rx_byte == CMD_MEM_2) || (rx_byte == CMD_MEM_3);

    // -----------------------------------------------------------------
    // Transmit path through the two-entry buffer
    // -----------------------------------------------------------------
    // Identity bits leave lowest first; search sends each bit then its
    // complement. The buffer ready stalls the index, so no bit is lost.
    assign push_valid = (state_reg == S_READ) ||
                        ((state_reg == S_SEARCH) && (phase_reg != PH_PICK));
    assign push_bit = ((state_reg == S_SEARCH) && (phase_reg == PH_COMP)) ? ~id_bit : id_bit;
    assign push_fire = push_valid && push_ready;

    ridc_fifo2 #(
        .WIDTH(1),
        .DEPTH(2),
        .AW(1)
    ) u_txbuf (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .flush_i(link_reset_i),
        .in_valid_i(push_valid),
        .in_data_i(push_bit),
        .in_ready_o(push_ready),
        .out_valid_o(tx_valid_o),
        .out_data_o(tx_bit_o),
        .out_ready_i(tx_ready_i)
    );

    // -----------------------------------------------------------------
    // Bit counter of the receive side
    // -----------------------------------------------------------------
    // Realigned on each link reset; in the identity phases it keeps
    // counting but only the byte states act on whole bytes.
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_shift_reg <= 8'h00;
            rx_cnt_reg <= 3'h0;
        end else if (link_reset_i) begin
            rx_shift_reg <= 8'h00;
            rx_cnt_reg <= 3'h0;
        end else if (rx_valid_i) begin
            rx_shift_reg <= rx_byte;
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
        end
    end

    // -----------------------------------------------------------------
    // Main sequencer
    // -----------------------------------------------------------------
    // A link reset always wins and returns to the command byte, except
    // while the check byte is still being built.
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= S_INIT;
            init_cnt_reg <= 7'h00;
            id_crc_reg <= 8'h00;
            id_ready_reg <= 1'b0;
            id_crc_ok_reg <= 1'b0;
            idx_reg <= 6'h00;
            phase_reg <= PH_TRUE;
            mismatch_reg <= 1'b0;
            selected_reg <= 1'b0;
            resume_reg <= 1'b0;
            mem_cmd_valid_reg <= 1'b0;
            mem_cmd_reg <= 8'h00;
            mem_data_valid_reg <= 1'b0;
            mem_data_reg <= 8'h00;
            cmd_reject_reg <= 1'b0;
        end else begin
            mem_cmd_valid_reg <= 1'b0;
            mem_data_valid_reg <= 1'b0;
            cmd_reject_reg <= 1'b0;
            if (link_reset_i && (state_reg != S_INIT)) begin
                state_reg <= S_ROMCMD;
                idx_reg <= 6'h00;
                phase_reg <= PH_TRUE;
                mismatch_reg <= 1'b0;
                selected_reg <= 1'b0;
            end else begin
                case (state_reg)
                    S_INIT: begin
                        init_cnt_reg <= init_cnt_reg + 7'h01;
                        if (init_cnt_reg == `RIDC_INIT_LATCH) begin
                            id_crc_reg <= crc_out;
                        end
                        if (init_cnt_reg == `RIDC_INIT_DONE) begin
                            id_crc_ok_reg <= (crc_out == 8'h00);
                            id_ready_reg <= 1'b1;
                            state_reg <= S_IDLE;
                        end
                    end
                    S_IDLE: begin
                        state_reg <= S_IDLE;
                    end
                    S_ROMCMD: begin
                        if (byte_done) begin
                            if (rx_byte == CMD_READ_ID) begin
                                state_reg <= S_READ;
                            end else if (rx_byte == CMD_MATCH_ID) begin
                                state_reg <= S_MATCH;
                            end else if (rx_byte == CMD_SEARCH_ID) begin
                                state_reg <= S_SEARCH;
                            end else if (rx_byte == CMD_SKIP_ID) begin
                                resume_reg <= 1'b0;
                                selected_reg <= 1'b1;
                                state_reg <= S_MEMCMD;
                            end else if ((rx_byte == CMD_RESUME) && resume_reg) begin
                                selected_reg <= 1'b1;
                                state_reg <= S_MEMCMD;
                            end else begin
                                // Memory codes here are refused too.
                                cmd_reject_reg <= !is_rom_cmd || is_mem_cmd;
                                state_reg <= S_IDLE;
                            end
                        end
                    end
                    S_READ: begin
                        if (push_fire) begin
                            idx_reg <= idx_reg + 6'h01;
                            if (idx_reg == `RIDC_LAST_ID_BIT) begin
                                resume_reg <= 1'b1;
                                selected_reg <= 1'b1;
                                state_reg <= S_MEMCMD;
                            end
                        end
                    end
                    S_MATCH: begin
                        if (rx_valid_i) begin
                            idx_reg <= idx_reg + 6'h01;
                            if (idx_reg == `RIDC_LAST_ID_BIT) begin
                                if (mismatch_reg || (rx_bit_i != id_bit)) begin
                                    state_reg <= S_IDLE;
                                end else begin
                                    resume_reg <= 1'b1;
                                    selected_reg <= 1'b1;
                                    state_reg <= S_MEMCMD;
                                end
                            end else if (rx_bit_i != id_bit) begin
                                mismatch_reg <= 1'b1;
                            end
                        end
                    end
                    S_SEARCH: begin
                        if (push_fire) begin
                            phase_reg <= (phase_reg == PH_TRUE) ? PH_COMP : PH_PICK;
                        end else if ((phase_reg == PH_PICK) && rx_valid_i) begin
                            // A master choosing the other branch drops us out.
                            if (rx_bit_i != id_bit) begin
                                state_reg <= S_IDLE;
                            end else if (idx_reg == `RIDC_LAST_ID_BIT) begin
                                resume_reg <= 1'b1;
                                selected_reg <= 1'b1;
                                state_reg <= S_MEMCMD;
                            end else begin
                                idx_reg <= idx_reg + 6'h01;
                                phase_reg <= PH_TRUE;
                            end
                        end
                    end
                    S_MEMCMD: begin
                        if (byte_done) begin
                            if (is_mem_cmd && selected_reg) begin
                                mem_cmd_valid_reg <= 1'b1;
                                mem_cmd_reg <= rx_byte;
                                state_reg <= S_DATA;
                            end else begin
                                cmd_reject_reg <= 1'b1;
                                state_reg <= S_IDLE;
                            end
                        end
                    end
                    S_DATA: begin
                        if (byte_done) begin
                            mem_data_valid_reg <= 1'b1;
                            mem_data_reg <= rx_byte;
                        end
                    end
                    default: begin
                        state_reg <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign id_ready_o = id_ready_reg;
    assign id_crc_ok_o = id_crc_ok_reg;
    assign id_crc_o = id_crc_reg;
    assign selected_o = selected_reg;
    assign mem_cmd_valid_o = mem_cmd_valid_reg;
    assign mem_cmd_o = mem_cmd_reg;
    assign mem_data_valid_o = mem_data_valid_reg;
    assign mem_data_o = mem_data_reg;
    assign cmd_reject_o = cmd_reject_reg;
endmodule

// *** test/ridc_monitor.sv ***
/* Port checker for ridc_top.
   Assumes a bind from the bench top, one clock, async reset. */
`timescale 1ns/1ps
module ridc_monitor (
    input wire mclk_i,
    input wire resetn_i,
    input wire link_reset_i,
    input wire tx_ready_i,
    input wire tx_valid_o,
    input wire tx_bit_o,
    input wire id_ready_o,
    input wire id_crc_ok_o,
    input wire [7:0] id_crc_o,
    input wire selected_o,
    input wire mem_cmd_valid_o,
    input wire cmd_reject_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    a_ready_sticky: assert property (id_ready_o |=> id_ready_o)
        else $error("identity ready dropped");
    a_crc_frozen: assert property (id_ready_o |=> $stable(id_crc_o))
        else $error("check byte moved");
    a_ok_at_ready: assert property ($rose(id_ready_o) |-> id_crc_ok_o)
        else $error("self check not clean");
    a_idle_early: assert property (!id_ready_o |-> !selected_o && !tx_valid_o)
        else $error("link active before ready");
    a_mem_after_sel: assert property (mem_cmd_valid_o |-> $past(selected_o))
        else $error("memory command unselected");
    a_sel_cleared: assert property (link_reset_i && id_ready_o |=> !selected_o)
        else $error("selection kept over reset");
    a_reject_pulse: assert property (cmd_reject_o |=> !cmd_reject_o)
        else $error("reject longer than one cycle");
    a_tx_held: assert property (tx_valid_o && !tx_ready_i && !link_reset_i
        |=> tx_valid_o && $stable(tx_bit_o))
        else $error("stalled tx bit lost");
    // Main scenarios reached.
    cover property (mem_cmd_valid_o);
    cover property (cmd_reject_o);
    cover property (tx_valid_o && !tx_ready_i);
endmodule

// *** test/ridc_master_model.sv ***
/* Behavioural bus master facing ridc_top: sends bits, takes tx bits.
   Assumes the bench calls its tasks and reads q. */
`timescale 1ns/1ps
module ridc_master_model (
    input wire mclk_i,
    output logic link_reset_i,
    output logic rx_valid_i,
    output logic rx_bit_i,
    output logic tx_ready_i,
    input wire tx_valid_o,
    input wire tx_bit_o
);
    logic q[$];
    // ------------------------------------------------------------
    // Bit transport
    // ------------------------------------------------------------
    initial begin
        link_reset_i = 1'b0;
        rx_valid_i = 1'b0;
        rx_bit_i = 1'b0;
        tx_ready_i = 1'b1;
    end
    // Bits are taken on edges where both sides agree.
    always @(posedge mclk_i) begin
        if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
            q.push_back(tx_bit_o);
        end
    end
    task set_ready(input logic r);
        @(posedge mclk_i);
        #1 tx_ready_i = r;
    endtask
    task pulse_reset();
        @(posedge mclk_i);
        #1 link_reset_i = 1'b1;
        @(posedge mclk_i);
        #1 link_reset_i = 1'b0;
    endtask
    // Data line shows the inverse outside a bit so stale values never match.
    task send_bit(input logic b);
        @(posedge mclk_i);
        #1 rx_valid_i = 1'b1;
        rx_bit_i = b;
        @(posedge mclk_i);
        #1 rx_valid_i = 1'b0;
        rx_bit_i = ~b;
    endtask
    task send_byte(input logic [7:0] v);
        integer i;
        for (i = 0; i < 8; i++) send_bit(v[i]);
    endtask
endmodule

// *** test/tb_rom_id_crc8_check.sv ***
/* Self-checking bench for ridc_top with a master model.
   Assumes design, model and monitor are compiled with it. */
`timescale 1ns/1ps
module tb_rom_id_crc8_check;
    localparam [7:0] FAM = 8'h5A;
    localparam [47:0] SER = 48'h0123456789AB;
    logic mclk_i, resetn_i, link_reset_i, rx_valid_i, rx_bit_i, tx_ready_i;
    logic tx_valid_o, tx_bit_o, id_ready_o, id_crc_ok_o, selected_o;
    logic mem_cmd_valid_o, mem_data_valid_o, cmd_reject_o;
    logic [7:0] id_crc_o, mem_cmd_o, mem_data_o, got_cmd, got_data;
    logic [63:0] idw;
    integer err_count = 0, samples_checked = 0, cmd_cnt = 0, rej_cnt = 0, bi;
    ridc_top #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER)) dut (.mclk_i(mclk_i),
        .resetn_i(resetn_i), .link_reset_i(link_reset_i), .rx_valid_i(rx_valid_i),
        .rx_bit_i(rx_bit_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
        .tx_bit_o(tx_bit_o), .id_ready_o(id_ready_o), .id_crc_ok_o(id_crc_ok_o),
        .id_crc_o(id_crc_o), .selected_o(selected_o), .mem_cmd_valid_o(mem_cmd_valid_o),
        .mem_cmd_o(mem_cmd_o), .mem_data_valid_o(mem_data_valid_o),
        .mem_data_o(mem_data_o), .cmd_reject_o(cmd_reject_o));
    ridc_master_model m (.mclk_i(mclk_i), .link_reset_i(link_reset_i),
        .rx_valid_i(rx_valid_i), .rx_bit_i(rx_bit_i), .tx_ready_i(tx_ready_i),
        .tx_valid_o(tx_valid_o), .tx_bit_o(tx_bit_o));
    // ------------------------------------------------------------
    // Clock, capture of pulses, helpers
    // ------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    // One-cycle pulses are counted where they stand.
    always @(posedge mclk_i) begin
        if (mem_cmd_valid_o === 1'b1) begin
            cmd_cnt <= cmd_cnt + 1;
            got_cmd <= mem_cmd_o;
        end
        if (mem_data_valid_o === 1'b1) got_data <= mem_data_o;
        if (cmd_reject_o === 1'b1) rej_cnt <= rej_cnt + 1;
    end
    // Reflected serial form of x^8+x^5+x^4+1, cleared first, bit 0 first.
    function automatic [7:0] crc8(input logic [63:0] d, input integer n);
        logic [7:0] c;
        integer i;
        c = 8'h00;
        for (i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
        return c;
    endfunction
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tally_and_finish();
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task wait_q(input integer n);
        integer k;
        k = 0;
        while (m.q.size() < n && k < 600) begin
            @(posedge mclk_i);
            k++;
        end
    endtask
    task cmd(input logic [7:0] c);
        m.pulse_reset();
        m.send_byte(c);
        repeat (2) @(posedge mclk_i);
    endtask
    task mem_op(input logic [7:0] c, input logic [7:0] d);
        integer c0;
        c0 = cmd_cnt;
        m.send_byte(c);
        repeat (2) @(posedge mclk_i);
        chk(cmd_cnt, c0 + 1);
        chk(got_cmd, c);
        m.send_byte(d);
        repeat (2) @(posedge mclk_i);
        chk(got_data, d);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_init();
        integer k;
        k = 0;
        while (id_ready_o !== 1'b1 && k < 200) begin
            @(posedge mclk_i);
            k++;
        end
        idw = {crc8({8'h00, SER, FAM}, 56), SER, FAM};
        chk(id_crc_o, idw[63:56]);
        chk(id_crc_ok_o, 1'b1);
        chk(crc8({id_crc_o, SER, FAM}, 64), 8'h00);
        $display("done: init");
    endtask
    task t_read();
        m.set_ready(1'b0);
        cmd(8'hA1);
        repeat (8) @(posedge mclk_i);
        chk(m.q.size(), 0);
        chk(tx_valid_o, 1'b1);
        m.set_ready(1'b1);
        wait_q(64);
        for (bi = 0; bi < 64; bi++) chk(m.q[bi], idw[bi]);
        m.q.delete();
        repeat (2) @(posedge mclk_i);
        chk(selected_o, 1'b1);
        mem_op(8'hB1, 8'h3C);
        $display("done: read");
    endtask
    task t_resume();
        cmd(8'hA5);
        chk(selected_o, 1'b1);
        mem_op(8'hB2, 8'hC3);
        cmd(8'hA4);
        chk(selected_o, 1'b1);
        mem_op(8'hB3, 8'h81);
        cmd(8'hA5);
        chk(selected_o, 1'b0);
        chk(rej_cnt, 0);
        $display("done: resume");
    endtask
    task t_match(input integer flip);
        integer i;
        cmd(8'hA2);
        for (i = 0; i < 64; i++) m.send_bit(idw[i] ^ (i == flip));
        repeat (2) @(posedge mclk_i);
        chk(selected_o, flip > 63);
        if (flip > 63) mem_op(8'hB4, 8'h7E);
        $display("done: match");
    endtask
    task t_search();
        integer i;
        cmd(8'hA3);
        for (i = 0; i < 64; i++) begin
            wait_q(2);
            chk({m.q[0], m.q[1]}, {idw[i], ~idw[i]});
            m.q.delete();
            m.send_bit(idw[i]);
        end
        repeat (2) @(posedge mclk_i);
        chk(selected_o, 1'b1);
        mem_op(8'hB1, 8'h00);
        $display("done: search");
    endtask
    task t_reject();
        integer r0;
        r0 = rej_cnt;
        cmd(8'hB2);
        chk(selected_o, 1'b0);
        cmd(8'h00);
        cmd(8'hA4);
        m.send_byte(8'hA1);
        repeat (2) @(posedge mclk_i);
        chk(rej_cnt, r0 + 3);
        $display("done: reject");
    endtask
    initial begin
        resetn_i = 1'b0;
        repeat (16) @(posedge mclk_i);
        #1 resetn_i = 1'b1;
        t_init();
        t_read();
        t_resume();
        t_match(99);
        t_match(40);
        chk(cmd_cnt, 4);
        t_search();
        t_reject();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_count++;
        tally_and_finish();
    end
endmodule
bind ridc_top ridc_monitor mon (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .link_reset_i(link_reset_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
    .tx_bit_o(tx_bit_o), .id_ready_o(id_ready_o), .id_crc_ok_o(id_crc_ok_o),
    .id_crc_o(id_crc_o), .selected_o(selected_o), .mem_cmd_valid_o(mem_cmd_valid_o),
    .cmd_reject_o(cmd_reject_o));
